// ---- ean_autoneg_control.sv ----
// negotiation control, strap handling and management registers for one port
//
// Function
// - strap disabled: force mode from ability straps
// - strap enabled: advertise per ability strap table
// - sample straps at reset into advert bits
// - control register writes override strap choice; under forced strap, enable must be cleared first
// - send advertisement register as pulse bursts
// - resolve 100 full, 100 half, 10 full, 10 half
// - forced speed/duplex from control bits only
// - report resolved speed in link summary
// - status ability bits fixed, t4 reads zero
// - status shows done, fault, link, preamble
// - advertisement resets to all until strap capture sets it, software may restrict
// - partner register loads base and next pages
// - parallel detect loads 0081 or 0021
// - expansion reports fault, np, page, partner able
// - both receivers watched during parallel detection
// - parallel detect leaves partner-able bit zero
// - fault when both links good
// - restart bit restarts negotiation anytime except under forced strap lock
// - lost negotiated link resumes negotiation
// - renegotiation halts transmit for break timer
// - negotiation completes within about three seconds
`timescale 1ns/10ps

module ean_autoneg_control #(
  parameter int BREAK_COUNT = ean_pkg::BREAK_CYCLES,     // break-link timer in clocks
  parameter int COMPLETE_COUNT = ean_pkg::COMPLETE_CYCLES, // negotiation give-up time in clocks
  parameter int PD_COUNT = ean_pkg::PD_CYCLES            // parallel detect settle in clocks
) (
  input wire logic clock,                    // core clock, 40 mhz
  input wire logic rst_b,                    // async reset, active low
  input wire logic [4:0] reg_addr,           // register address
  input wire logic [15:0] reg_wdata,         // register write data
  input wire logic reg_write,                // write strobe
  input wire logic reg_read,                 // read strobe
  output logic [15:0] reg_rdata,             // read data, cycle after strobe
  input wire logic negotiate_strap_enable,   // strap: negotiation enable
  input wire logic ability_strap_high,       // strap: ability high bit
  input wire logic ability_strap_low,        // strap: ability low bit
  input wire logic line_good_100,            // 100 receiver sees valid link
  input wire logic line_good_10,             // 10 receiver sees valid link
  input wire logic rx_page_valid,            // one-cycle pulse, partner word received
  input wire logic [15:0] rx_page_word,      // received partner code word
  output logic flp_enable,                   // send pulse bursts
  output logic tx_halt,                      // stop all transmit data and pulses
  output logic [15:0] tx_page_word,          // code word to send in bursts
  output logic link_up,                      // valid link in resolved mode
  output logic speed_100,                    // resolved or forced speed is 100
  output logic full_duplex,                  // resolved or forced duplex is full
  output logic neg_complete                  // negotiation finished
);
  import ean_pkg::*;

  // ------------------------------------------------------------
  // register map and limitations
  // ------------------------------------------------------------
  // 0x00 control: speed, enable, restart, duplex
  // 0x01 status: fixed abilities, done, fault, link
  // 0x04 advertisement, whole word writable
  // 0x05 partner word, read only
  // 0x06 expansion: fault, page flags clear on read
  // 0x10 summary: link, 10 mb/s, full, done
  // any other offset reads zero
  // local next page unsupported, reads zero
  // detect fault needs both receivers good
  // live link status, a short drop may be missed
  // a write wins over a sequence step
  // straps must hold from reset until capture
  // give-up after the window retries via break
  // next pages are stored, only the last resolves

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // advertised abilities selected by the ability straps
  function automatic logic [3:0] strap_advert(input logic [1:0] ab);
    logic [3:0] v;
    v = 4'h0;
    unique case (ab)
      2'b00: v = 4'h3;
      2'b01: v = 4'hc;
      2'b10: v = 4'h5;
      2'b11: v = 4'hf;
    endcase
    return v;
  endfunction

  // highest common mode: {found, is_100, is_full}
  function automatic logic [2:0] resolve(input logic [3:0] common);
    logic [2:0] v;
    v = 3'b000;
    if (common[3]) begin
      v = 3'b111;
    end else if (common[2]) begin
      v = 3'b110;
    end else if (common[1]) begin
      v = 3'b101;
    end else if (common[0]) begin
      v = 3'b100;
    end
    return v;
  endfunction

  localparam ean_regs_type REGS_RESET = '{
    state: ST_FORCED,
    advert: ADVERT_RESET,
    default: '0
  };

  ean_regs_type r;
  ean_regs_type n;
  logic [2:0] res;
  logic sel_good;
  logic neg_active;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    res = resolve(r.advert[ADV_ABIL_LSB +: 4] & rx_page_word[ADV_ABIL_LSB +: 4]);
    sel_good = r.res_100 ? r.g100 : r.g10;
    neg_active = r.ctl_neg_en & ~r.forced_lock;

    // pin synchronisers; a level counts once stages two and three agree
    n.strap_s0 = {negotiate_strap_enable, ability_strap_high, ability_strap_low};
    n.strap_s1 = r.strap_s0;
    n.strap_s2 = r.strap_s1;
    if (r.strap_s1 == r.strap_s2) begin
      n.strap_f = r.strap_s2;
    end
    n.g100_s = {r.g100_s[1:0], line_good_100};
    n.g10_s = {r.g10_s[1:0], line_good_10};
    if (r.g100_s[1] == r.g100_s[2]) begin
      n.g100 = r.g100_s[2];
    end
    if (r.g10_s[1] == r.g10_s[2]) begin
      n.g10 = r.g10_s[2];
    end

    // read mux; flags cleared by read are set again below if an event coincides
    n.rdata = 16'h0000;
    if (reg_read) begin
      unique case (reg_addr)
        REG_BASIC_MODE_CONTROL: begin
          n.rdata[CTL_SPEED_BIT] = r.ctl_speed;
          n.rdata[CTL_NEG_EN_BIT] = r.ctl_neg_en;
          n.rdata[CTL_RESTART_BIT] = r.ctl_restart;
          n.rdata[CTL_DUPLEX_BIT] = r.ctl_duplex;
        end
        REG_BASIC_MODE_STATUS: begin
          n.rdata = STATUS_ABILITY_BITS;
          n.rdata[STS_NEG_DONE_BIT] = r.neg_done;
          n.rdata[STS_REMOTE_FAULT_BIT] = r.partner[WORD_REMOTE_FAULT_BIT];
          n.rdata[STS_LINK_BIT] = r.link_ok;
        end
        REG_ABILITY_ADVERTISEMENT: n.rdata = r.advert;
        REG_PARTNER_ABILITY: n.rdata = r.partner;
        REG_NEGOTIATION_EXPANSION: begin
          n.rdata[EXP_PD_FAULT_BIT] = r.exp_pd_fault;
          n.rdata[EXP_PARTNER_NP_BIT] = r.exp_partner_np;
          n.rdata[EXP_LOCAL_NP_BIT] = 1'b0;
          n.rdata[EXP_PAGE_RX_BIT] = r.exp_page_rx;
          n.rdata[EXP_PARTNER_NEG_BIT] = r.exp_partner_neg;
          n.exp_pd_fault = 1'b0;
          n.exp_page_rx = 1'b0;
        end
        REG_LINK_STATUS_SUMMARY: begin
          n.rdata[SUM_LINK_BIT] = r.link_ok;
          n.rdata[SUM_SPEED_10_BIT] = r.link_ok & ~r.res_100;
          n.rdata[SUM_DUPLEX_BIT] = r.link_ok & r.res_full;
          n.rdata[SUM_NEG_DONE_BIT] = r.neg_done;
        end
        default: n.rdata = 16'h0000;
      endcase
    end

    // strap capture shortly after reset release
    if (!r.strap_done) begin
      n.strap_cnt = r.strap_cnt + 3'h1;
      if (r.strap_cnt == STRAP_SETTLE) begin
        n.strap_done = 1'b1;
        if (r.strap_f[2]) begin
          n.ctl_neg_en = 1'b1;
          n.advert[ADV_ABIL_LSB +: 4] = strap_advert(r.strap_f[1:0]);
          n.state = ST_ABILITY;
          n.flp_on = 1'b1;
          n.timer = 32'h0;
        end else begin
          n.ctl_neg_en = 1'b0;
          n.ctl_speed = r.strap_f[1];
          n.ctl_duplex = r.strap_f[0];
          n.advert[ADV_ABIL_LSB +: 4] = 4'h1 << {r.strap_f[1], r.strap_f[0]};
          // forced strap locks out software enable
          n.forced_lock = 1'b1;
        end
      end
    end

    // ------------------------------------------------------------
    // negotiation sequence
    // ------------------------------------------------------------
    unique case (r.state)
      ST_FORCED: begin
        // speed and duplex from control bits
        n.flp_on = 1'b0;
        n.tx_halt = 1'b0;
        n.neg_done = 1'b0;
        // bits have no effect while enable is set
        if (!r.ctl_neg_en) begin
          n.res_100 = r.ctl_speed;
          n.res_full = r.ctl_duplex;
        end
        n.link_ok = sel_good;
      end
      ST_BREAK: begin
        n.tx_halt = 1'b1;
        n.flp_on = 1'b0;
        n.ctl_restart = 1'b0;
        n.timer = r.timer + 32'h1;
        if (r.timer == 32'(BREAK_COUNT - 1)) begin
          n.state = ST_ABILITY;
          n.timer = 32'h0;
          n.pd_cnt = 32'h0;
          n.tx_halt = 1'b0;
          n.flp_on = 1'b1;
        end
      end
      ST_ABILITY: begin
        n.flp_on = 1'b1;
        n.timer = r.timer + 32'h1;
        if (rx_page_valid) begin
          n.partner = rx_page_word;
          n.exp_page_rx = 1'b1;
          n.exp_partner_neg = 1'b1;
          n.exp_partner_np = rx_page_word[WORD_NEXT_PAGE_BIT];
          n.pd_cnt = 32'h0;
          if (!rx_page_word[WORD_NEXT_PAGE_BIT]) begin
            n.res_100 = res[1];
            n.res_full = res[0];
            n.state = res[2] ? ST_LINK_WAIT : ST_BREAK;
            n.flp_on = 1'b0;
            n.timer = 32'h0;
          end
        end else if (r.g100 ^ r.g10) begin
          n.pd_cnt = r.pd_cnt + 32'h1;
          if (r.pd_cnt == 32'(PD_COUNT - 1)) begin
            // fixed partner word on parallel detect
            n.partner = r.g100 ? PD_WORD_100 : PD_WORD_10;
            n.exp_partner_neg = 1'b0;
            n.res_100 = r.g100;
            n.res_full = 1'b0;
            n.neg_done = 1'b1;
            n.link_ok = 1'b1;
            n.flp_on = 1'b0;
            n.state = ST_GOOD;
          end
        end else begin
          n.pd_cnt = 32'h0;
          // two good links is a detect fault
          if (r.g100 & r.g10) begin
            n.exp_pd_fault = 1'b1;
          end
        end
        // give up and restart after the completion window
        if (r.timer == 32'(COMPLETE_COUNT - 1)) begin
          n.state = ST_BREAK;
          n.timer = 32'h0;
          n.flp_on = 1'b0;
        end
      end
      ST_LINK_WAIT: begin
        n.timer = r.timer + 32'h1;
        if (sel_good) begin
          n.state = ST_GOOD;
          n.neg_done = 1'b1;
          n.link_ok = 1'b1;
        end else if (r.timer == 32'(COMPLETE_COUNT - 1)) begin
          n.state = ST_BREAK;
          n.timer = 32'h0;
        end
      end
      ST_GOOD: begin
        if (!sel_good) begin
          n.state = ST_BREAK;
          n.timer = 32'h0;
          n.neg_done = 1'b0;
          n.link_ok = 1'b0;
        end
      end
    endcase

    // ------------------------------------------------------------
    // register writes; a write request overrides the sequence above
    // ------------------------------------------------------------
    if (reg_write) begin
      unique case (reg_addr)
        REG_BASIC_MODE_CONTROL: begin
          n.ctl_speed = reg_wdata[CTL_SPEED_BIT];
          n.ctl_duplex = reg_wdata[CTL_DUPLEX_BIT];
          n.ctl_neg_en = reg_wdata[CTL_NEG_EN_BIT];
          if (!reg_wdata[CTL_NEG_EN_BIT]) begin
            // clearing the enable releases the lock
            n.forced_lock = 1'b0;
            n.ctl_restart = 1'b0;
            n.state = ST_FORCED;
            n.neg_done = 1'b0;
            n.link_ok = 1'b0;
          end else if (!r.forced_lock && (!r.ctl_neg_en || reg_wdata[CTL_RESTART_BIT])) begin
            n.ctl_restart = reg_wdata[CTL_RESTART_BIT] & neg_active;
            n.state = ST_BREAK;
            n.timer = 32'h0;
            n.neg_done = 1'b0;
            n.link_ok = 1'b0;
            n.flp_on = 1'b0;
            n.tx_halt = 1'b1;
          end
        end
        REG_ABILITY_ADVERTISEMENT: n.advert = reg_wdata;
        default: n.advert = n.advert;
      endcase
    end

    n.tx_word = n.advert;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r <= REGS_RESET;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign reg_rdata = r.rdata;
  assign flp_enable = r.flp_on;
  assign tx_halt = r.tx_halt;
  assign tx_page_word = r.tx_word;
  assign link_up = r.link_ok;
  assign speed_100 = r.res_100;
  assign full_duplex = r.res_full;
  assign neg_complete = r.neg_done;

endmodule

// ---- ean_autoneg_monitor.sv ----
// checker for the negotiation control block ports
`timescale 1ns/10ps
module ean_autoneg_monitor import ean_pkg::*; #(
  parameter int BREAK_COUNT = 20 // break timer in clocks
) (
  input wire logic clock, // core clock
  input wire logic rst_b, // async reset
  input wire logic [4:0] reg_addr, // address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_write, // write strobe
  input wire logic reg_read, // read strobe
  input wire logic [15:0] reg_rdata, // read data
  input wire logic rx_page_valid, // partner word strobe
  input wire logic [15:0] rx_page_word, // partner word
  input wire logic flp_enable, // bursts on
  input wire logic tx_halt, // transmit stopped
  input wire logic [15:0] tx_page_word, // sent word
  input wire logic link_up, // link good
  input wire logic speed_100, // speed
  input wire logic full_duplex // duplex
);
  // ----------------------------------------
  // helper: length of the current halt
  // ----------------------------------------
  logic [31:0] halt_cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) halt_cnt <= 32'h0;
    else if (tx_halt) halt_cnt <= halt_cnt + 32'h1;
    else halt_cnt <= 32'h0;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_last_page;
    rx_page_valid && flp_enable && !rx_page_word[WORD_NEXT_PAGE_BIT];
  endsequence
  sequence s_adv_write;
    reg_write && reg_addr == REG_ABILITY_ADVERTISEMENT ##1 !reg_write [*2];
  endsequence
  property p_status; $past(reg_read) && $past(reg_addr) == REG_BASIC_MODE_STATUS |->
    (reg_rdata & STATUS_ABILITY_BITS) == STATUS_ABILITY_BITS && !reg_rdata[15]; endproperty
  a_status: assert property (p_status) else $error("status ability bits wrong");
  property p_halt_quiet; tx_halt |-> !flp_enable && !link_up; endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("activity during halt");
  property p_restart_halt; reg_write && reg_addr == REG_BASIC_MODE_CONTROL && reg_wdata[CTL_RESTART_BIT]
    && reg_wdata[CTL_NEG_EN_BIT] |=> tx_halt; endproperty
  a_restart_halt: assert property (p_restart_halt) else $error("restart did not halt");
  // a timer that counts too few or too many shows here
  property p_break_len; $fell(tx_halt) |-> $past(halt_cnt) + 2 >= BREAK_COUNT && $past(halt_cnt) <= BREAK_COUNT + 1;
  endproperty
  a_break_len: assert property (p_break_len) else $error("break length wrong");
  property p_flp_after; $fell(tx_halt) |-> flp_enable; endproperty
  a_flp_after: assert property (p_flp_after) else $error("no bursts after break");
  property p_flp_no_link; flp_enable |-> !link_up; endproperty
  a_flp_no_link: assert property (p_flp_no_link) else $error("bursts with link up");
  property p_res; s_last_page ##0 tx_page_word[8] && rx_page_word[8] |=> !flp_enable && speed_100 && full_duplex;
  endproperty
  a_res: assert property (p_res) else $error("top mode not chosen");
  property p_restart_clear; $past(reg_read) && $past(reg_addr) == REG_BASIC_MODE_CONTROL && $past(tx_halt)
    && $past(tx_halt, 2) |-> !reg_rdata[CTL_RESTART_BIT]; endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart bit stuck");
  property p_tx_word; s_adv_write |-> tx_page_word == $past(reg_wdata, 2); endproperty
  a_tx_word: assert property (p_tx_word) else $error("sent word not advert");
endmodule
bind ean_autoneg_control ean_autoneg_monitor #(.BREAK_COUNT(BREAK_COUNT)) u_mon (.clock(clock), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word), .flp_enable(flp_enable), .tx_halt(tx_halt),
  .tx_page_word(tx_page_word), .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex));

// ---- ean_link_partner.sv ----
// behavioural remote link partner
`timescale 1ns/10ps
module ean_link_partner (
  input wire logic clock, // core clock
  input wire logic rst_b, // async reset
  input wire logic flp_enable, // our bursts heard
  input wire logic send, // command: answer with word
  input wire logic [15:0] word, // word to answer
  input wire logic [3:0] lag, // answer delay
  input wire logic good_100, // partner sends 100 signal
  input wire logic good_10, // partner sends 10 pulses
  output logic line_good_100, // 100 receiver status
  output logic line_good_10, // 10 receiver status
  output logic rx_page_valid, // word strobe
  output logic [15:0] rx_page_word // received word
);
  logic pend;
  logic [3:0] cnt;
  // word only answers heard bursts; bus toggles when idle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {pend, cnt, rx_page_valid, line_good_100, line_good_10} <= 8'h0;
      rx_page_word <= 16'h0;
    end else begin
      rx_page_valid <= 1'b0;
      rx_page_word <= ~rx_page_word;
      if (send) begin
        pend <= 1'b1;
        cnt <= lag;
      end else if (pend && flp_enable && cnt == 4'h0) begin
        pend <= 1'b0;
        rx_page_valid <= 1'b1;
        rx_page_word <= word;
      end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      line_good_100 <= good_100;
      line_good_10 <= good_10;
    end
  end
endmodule

// ---- ean_pkg.sv ----
// constants and types for the ethernet negotiation control block
package ean_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] REG_BASIC_MODE_CONTROL = 5'h00;
  localparam logic [4:0] REG_BASIC_MODE_STATUS = 5'h01;
  localparam logic [4:0] REG_ABILITY_ADVERTISEMENT = 5'h04;
  localparam logic [4:0] REG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] REG_NEGOTIATION_EXPANSION = 5'h06;
  localparam logic [4:0] REG_LINK_STATUS_SUMMARY = 5'h10;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL_SPEED_BIT = 13;
  localparam int CTL_NEG_EN_BIT = 12;
  localparam int CTL_RESTART_BIT = 9;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int STS_NEG_DONE_BIT = 5;
  localparam int STS_REMOTE_FAULT_BIT = 4;
  localparam int STS_LINK_BIT = 2;
  localparam int ADV_ABIL_LSB = 5;           // abilities {100fd,100hd,10fd,10hd} at [8:5]
  localparam int WORD_NEXT_PAGE_BIT = 15;
  localparam int WORD_REMOTE_FAULT_BIT = 13;
  localparam int EXP_PD_FAULT_BIT = 4;
  localparam int EXP_PARTNER_NP_BIT = 3;
  localparam int EXP_LOCAL_NP_BIT = 2;
  localparam int EXP_PAGE_RX_BIT = 1;
  localparam int EXP_PARTNER_NEG_BIT = 0;
  localparam int SUM_LINK_BIT = 0;
  localparam int SUM_SPEED_10_BIT = 1;
  localparam int SUM_DUPLEX_BIT = 2;
  localparam int SUM_NEG_DONE_BIT = 4;

  // ------------------------------------------------------------
  // fixed and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] STATUS_ABILITY_BITS = 16'h7849;  // no t4, all others, preamble supp
  localparam logic [15:0] ADVERT_RESET = 16'h01e1;
  localparam logic [15:0] PD_WORD_100 = 16'h0081;
  localparam logic [15:0] PD_WORD_10 = 16'h0021;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int BREAK_LINK_MS = 1500;
  localparam int COMPLETE_MAX_MS = 3000;
  localparam int PD_SETTLE_MS = 10;
  localparam int BREAK_CYCLES = BREAK_LINK_MS * (CLK_HZ / 1000);
  localparam int COMPLETE_CYCLES = COMPLETE_MAX_MS * (CLK_HZ / 1000);
  localparam int PD_CYCLES = PD_SETTLE_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------
  // state and storage types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_FORCED = 5'b00001,
    ST_BREAK = 5'b00010,
    ST_ABILITY = 5'b00100,
    ST_LINK_WAIT = 5'b01000,
    ST_GOOD = 5'b10000
  } ean_state_type;

  typedef struct packed {
    ean_state_type state;
    logic [2:0] strap_s0;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [2:0] strap_f;
    logic [2:0] strap_cnt;
    logic strap_done;
    logic [2:0] g100_s;
    logic [2:0] g10_s;
    logic g100;
    logic g10;
    logic ctl_speed;
    logic ctl_neg_en;
    logic ctl_duplex;
    logic ctl_restart;
    logic forced_lock;
    logic [15:0] advert;
    logic [15:0] partner;
    logic exp_pd_fault;
    logic exp_page_rx;
    logic exp_partner_neg;
    logic exp_partner_np;
    logic neg_done;
    logic link_ok;
    logic res_100;
    logic res_full;
    logic [31:0] timer;
    logic [31:0] pd_cnt;
    logic [15:0] rdata;
    logic flp_on;
    logic tx_halt;
    logic [15:0] tx_word;
  } ean_regs_type;

endpackage

// ---- tb_top.sv ----
// self-checking bench for the negotiation control block
`timescale 1ns/10ps
module tb_top;
  import ean_pkg::*;
  logic clock, rst_b, reg_write, reg_read, rd_seen, neg_s, ab_hi, ab_lo, lg100, lg10, rx_v;
  logic flp_enable, tx_halt, link_up, speed_100, full_duplex, neg_complete, sp_send, sp_g100, sp_g10;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rx_w, tx_w, sp_word, v;
  logic [3:0] sp_lag;
  logic [15:0] exp_q[$];
  int fails, check_count, seed;
  logic [15:0] adv_t [8] = '{16'h0021, 16'h0041, 16'h0081, 16'h0101, 16'h0061, 16'h0181, 16'h00a1, 16'h01e1};
  logic [15:0] pw_t [4] = '{16'h01e1, 16'h00a1, 16'h0061, 16'h0021};
  ean_autoneg_control #(.BREAK_COUNT(20), .COMPLETE_COUNT(200), .PD_COUNT(8)) u_dut (.clock(clock),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .negotiate_strap_enable(neg_s), .ability_strap_high(ab_hi), .ability_strap_low(ab_lo),
    .line_good_100(lg100), .line_good_10(lg10), .rx_page_valid(rx_v), .rx_page_word(rx_w),
    .flp_enable(flp_enable), .tx_halt(tx_halt), .tx_page_word(tx_w), .link_up(link_up), .speed_100(speed_100),
    .full_duplex(full_duplex), .neg_complete(neg_complete));
  ean_link_partner u_lp (.clock(clock), .rst_b(rst_b), .flp_enable(flp_enable), .send(sp_send), .word(sp_word),
    .lag(sp_lag), .good_100(sp_g100), .good_10(sp_g10), .line_good_100(lg100), .line_good_10(lg10),
    .rx_page_valid(rx_v), .rx_page_word(rx_w));
  // 40 mhz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return tx_halt;
      1: return flp_enable;
      2: return link_up;
      default: return neg_complete;
    endcase
  endfunction
  // bounded wait, a miss counts as mismatch
  task automatic wt(input int s, input logic e);
    #1;
    for (int k = 0; k < 400 && pick(s) !== e; k++) begin
      @(posedge clock);
      #1;
    end
    chk({15'h0, pick(s)}, {15'h0, e});
  endtask
  task automatic send(input logic [15:0] w, input logic [3:0] lag);
    @(posedge clock);
    sp_send <= 1'b1;
    sp_word <= w;
    sp_lag <= lag;
    @(posedge clock);
    sp_send <= 1'b0;
  endtask
  task automatic lines(input logic a, input logic b);
    @(posedge clock);
    sp_g100 <= a;
    sp_g10 <= b;
  endtask
  // straps held from reset well past capture
  task automatic strap_reset(input logic [2:0] s);
    @(posedge clock);
    rst_b <= 1'b0;
    {neg_s, ab_hi, ab_lo} <= s;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // read data is judged in the cycle after its strobe
  always @(negedge clock) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front());
    rd_seen = reg_read;
  end
  // watchdog, far beyond the expected few hundred cycles
  initial begin
    #(25 * 20000);
    fails++;
    end_of_test;
  end
  initial begin
    {seed, fails, check_count} = {32'd71145, 64'd0};
    {rst_b, reg_write, reg_read, rd_seen, sp_send, sp_g100, sp_g10, neg_s, ab_hi, ab_lo} = 10'h0;
    {reg_addr, reg_wdata, sp_word, sp_lag} = 41'h0;
    for (int i = 0; i < 8; i++) begin
      strap_reset(3'(i));
      rd(REG_ABILITY_ADVERTISEMENT, adv_t[i]);
      rd(REG_BASIC_MODE_CONTROL, {2'h0, i[1] & ~i[2], i[2], 3'h0, i[0] & ~i[2], 8'h0});
      #1;
      if (!i[2]) chk({14'h0, speed_100, full_duplex}, {14'h0, i[1], i[0]});
      if (i == 3) begin
        wr(REG_BASIC_MODE_CONTROL, 16'h1000);
        rd(REG_BASIC_MODE_CONTROL, 16'h1000);
        wt(0, 1'b0);
        chk({14'h0, speed_100, full_duplex}, 16'h0003);
        wr(REG_BASIC_MODE_CONTROL, 16'h0000);
        wr(REG_BASIC_MODE_CONTROL, 16'h1000);
        wt(0, 1'b1);
      end
      $display("strap test %0d done", i);
    end
    wr(REG_PARTNER_ABILITY, 16'hffff);
    rd(REG_PARTNER_ABILITY, 16'h0000);
    rd(5'h1f, 16'h0000);
    rd(REG_BASIC_MODE_STATUS, STATUS_ABILITY_BITS);
    rd(REG_NEGOTIATION_EXPANSION, 16'h0000);
    repeat (4) begin
      v = 16'($random(seed));
      wr(REG_ABILITY_ADVERTISEMENT, v);
      rd(REG_ABILITY_ADVERTISEMENT, v);
      chk(tx_w, v);
    end
    wr(REG_ABILITY_ADVERTISEMENT, ADVERT_RESET);
    // one step per priority level, each ended by link loss
    for (int i = 0; i < 4; i++) begin
      wr(REG_BASIC_MODE_CONTROL, 16'h1200);
      rd(REG_BASIC_MODE_CONTROL, 16'h1000);
      wt(0, 1'b0);
      wt(1, 1'b1);
      send(16'h8001, 4'h0);
      repeat (2) @(posedge clock);
      rd(REG_NEGOTIATION_EXPANSION, 16'h000b);
      rd(REG_PARTNER_ABILITY, 16'h8001);
      send(pw_t[i], 4'(i * 3));
      wt(1, 1'b0);
      lines(i < 2, i >= 2);
      wt(2, 1'b1);
      chk({13'h0, neg_complete, speed_100, full_duplex}, {13'h0, 1'b1, i < 2, ~i[0]});
      rd(REG_PARTNER_ABILITY, pw_t[i]);
      rd(REG_NEGOTIATION_EXPANSION, 16'h0003);
      rd(REG_BASIC_MODE_STATUS, STATUS_ABILITY_BITS | 16'h0024);
      rd(REG_LINK_STATUS_SUMMARY, {11'h0, 1'b1, 1'b0, ~i[0], i >= 2, 1'b1});
      lines(1'b0, 1'b0);
      wt(0, 1'b1);
      $display("priority step %0d done", i);
    end
    wt(0, 1'b0);
    lines(1'b0, 1'b1);
    wt(3, 1'b1);
    chk({13'h0, link_up, speed_100, full_duplex}, 16'h0004);
    rd(REG_PARTNER_ABILITY, PD_WORD_10);
    rd(REG_NEGOTIATION_EXPANSION, 16'h0000);
    lines(1'b0, 1'b0);
    wt(0, 1'b1);
    wt(0, 1'b0);
    lines(1'b1, 1'b1);
    repeat (16) @(posedge clock);
    rd(REG_NEGOTIATION_EXPANSION, 16'h0010);
    wt(3, 1'b0);
    wt(0, 1'b1);
    wt(0, 1'b0);
    $display("parallel detect done");
    wr(REG_BASIC_MODE_CONTROL, 16'h2100);
    wt(2, 1'b1);
    chk({13'h0, flp_enable, speed_100, full_duplex}, 16'h0003);
    lines(1'b0, 1'b1);
    wr(REG_BASIC_MODE_CONTROL, 16'h0000);
    repeat (6) @(posedge clock);
    wt(2, 1'b1);
    chk({14'h0, speed_100, full_duplex}, 16'h0000);
    $display("forced mode done");
    end_of_test;
  end
endmodule
